// file: cmo_pkg.sv
// Purpose: Constants for the cache maintenance operation engine
// Assumes: One core clock, cache arrays sit outside this block
// Notes: Offsets, widths, reset values and codes live here
package cmo_pkg;
  localparam int OP_HI = 20;
  localparam int OP_LO = 18;
  localparam int SEL_HI = 17;
  localparam int SEL_LO = 16;
  localparam int ADDR_W = 32;
  localparam int TAG_W = 32;
  localparam int DATA_W = 32;
  localparam int IDX_HI = 13;
  localparam int IDX_LO = 5;
  localparam int IDX_W = IDX_HI - IDX_LO + 1;
  localparam int LINE_OFF_W = IDX_LO;
  localparam int DATA_ALIGN_LO = 3;
  localparam logic [2:0] OP_IDX_INV = 3'h0;
  localparam logic [2:0] OP_LOAD_TAG = 3'h1;
  localparam logic [2:0] OP_STORE_TAG = 3'h2;
  localparam logic [2:0] OP_IMPL = 3'h3;
  localparam logic [2:0] OP_HIT_INV = 3'h4;
  localparam logic [1:0] SEL_PI = 2'h0;
  localparam logic [1:0] SEL_PD = 2'h1;
  localparam logic [1:0] SEL_TER = 2'h2;
  localparam logic [1:0] SEL_SEC = 2'h3;
  localparam logic [31:0] TAG_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [3:0] WB_CACHES_RST = 4'h0;
  typedef enum logic [2:0] {
    CMO_IDLE, CMO_READ, CMO_WAIT, CMO_WB, CMO_WRITE, CMO_DONE
  } cmo_state_t;
endpackage

// file: cmo_engine.sv
// Purpose: Executes cache maintenance codes 0 to 3 on one of four caches, code 4 on the two primary caches only
// Assumes: Array read data valid one cycle after rd_req; single clock
// Notes: Pipeline held by busy until done pulses
`timescale 1ns/1ps
module cmo_engine (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire logic [31:0] op_instr,
  input wire logic [cmo_pkg::ADDR_W-1:0] op_addr,
  output logic op_busy,
  output logic op_done,
  output logic op_cache_err,
  input wire logic [3:0] cache_wb_mode,
  input wire logic tag_low_wr,
  input wire logic tag_high_wr,
  input wire logic [cmo_pkg::TAG_W-1:0] tag_wdata,
  output logic [cmo_pkg::TAG_W-1:0] tag_low_holding_reg,
  output logic [cmo_pkg::TAG_W-1:0] tag_high_holding_reg,
  output logic [cmo_pkg::DATA_W-1:0] data_low_holding_reg,
  output logic [cmo_pkg::DATA_W-1:0] data_high_holding_reg,
  output logic arr_rd_req,
  output logic arr_wr_req,
  output logic [1:0] arr_sel,
  output logic [cmo_pkg::IDX_W-1:0] arr_index,
  output logic [cmo_pkg::ADDR_W-1:0] arr_addr,
  output logic [cmo_pkg::TAG_W-1:0] arr_wtag_low,
  output logic [cmo_pkg::TAG_W-1:0] arr_wtag_high,
  output logic arr_wvalid,
  input wire logic [cmo_pkg::TAG_W-1:0] arr_rtag_low,
  input wire logic [cmo_pkg::TAG_W-1:0] arr_rtag_high,
  input wire logic [cmo_pkg::DATA_W-1:0] arr_rdata_low,
  input wire logic [cmo_pkg::DATA_W-1:0] arr_rdata_high,
  input wire logic arr_rvalid_bit,
  input wire logic arr_rdirty_bit,
  input wire logic arr_rparity_err,
  output logic mem_wb_req,
  output logic [cmo_pkg::ADDR_W-1:0] mem_wb_addr,
  input wire logic mem_wb_done,
  output logic impl_op_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  cmo_pkg::cmo_state_t state_reg;
  logic [2:0] op_reg;
  logic [1:0] sel_reg;
  logic [cmo_pkg::ADDR_W-1:0] addr_reg;
  logic is_hit;
  logic [cmo_pkg::ADDR_W-1:0] tag_addr;
  logic [3:0] wb_cache;
  logic wb_go;
  logic hit_go;

  assign op_busy = (state_reg != cmo_pkg::CMO_IDLE) | op_valid;
  assign arr_sel = sel_reg;
  assign arr_index = addr_reg[cmo_pkg::IDX_HI:cmo_pkg::IDX_LO];
  // Aligned access, low byte bits cleared
  assign arr_addr = {addr_reg[cmo_pkg::ADDR_W-1:cmo_pkg::DATA_ALIGN_LO],
                     {cmo_pkg::DATA_ALIGN_LO{1'b0}}};
  assign arr_rd_req = (state_reg == cmo_pkg::CMO_READ);
  assign is_hit = arr_rvalid_bit &
    (arr_rtag_low[cmo_pkg::ADDR_W-1:cmo_pkg::IDX_HI+1] ==
     addr_reg[cmo_pkg::ADDR_W-1:cmo_pkg::IDX_HI+1]);
  // Line address rebuilt from stored tag
  assign tag_addr = {arr_rtag_low[cmo_pkg::ADDR_W-1:cmo_pkg::IDX_HI+1],
                     addr_reg[cmo_pkg::IDX_HI:cmo_pkg::IDX_LO],
                     {cmo_pkg::LINE_OFF_W{1'b0}}};

  // Write-back policy per select; primary I-cache is never dirty
  for (genvar gi = 0; gi < 4; gi++) begin : g_wb_mode
    if (gi == 0) begin : g_icache
      assign wb_cache[gi] = 1'b0;
    end else begin : g_other
      assign wb_cache[gi] = cache_wb_mode[gi];
    end
  end
  assign wb_go = wb_cache[sel_reg] & arr_rvalid_bit &
    arr_rdirty_bit;
  assign hit_go = is_hit & ~sel_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= cmo_pkg::CMO_IDLE;
    end else if (clk_en) begin
      unique case (state_reg)
        cmo_pkg::CMO_IDLE: begin
          if (op_valid) begin
            state_reg <= cmo_pkg::CMO_READ;
          end
        end
        cmo_pkg::CMO_READ: begin
          state_reg <= cmo_pkg::CMO_WAIT;
        end
        cmo_pkg::CMO_WAIT: begin
          if (op_reg == cmo_pkg::OP_IDX_INV && wb_go) begin
            state_reg <= cmo_pkg::CMO_WB;
          end else begin
            state_reg <= cmo_pkg::CMO_DONE;
          end
        end
        cmo_pkg::CMO_WB: begin
          if (mem_wb_done) begin
            state_reg <= cmo_pkg::CMO_DONE;
          end
        end
        cmo_pkg::CMO_WRITE: begin
          state_reg <= cmo_pkg::CMO_DONE;
        end
        cmo_pkg::CMO_DONE: begin
          state_reg <= cmo_pkg::CMO_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request capture

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_reg <= 3'h0;
      sel_reg <= 2'h0;
      addr_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == cmo_pkg::CMO_IDLE && op_valid) begin
        op_reg <= op_instr[cmo_pkg::OP_HI:cmo_pkg::OP_LO];
        sel_reg <= op_instr[cmo_pkg::SEL_HI:cmo_pkg::SEL_LO];
        addr_reg <= op_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writeback

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_wb_req <= 1'b0;
      mem_wb_addr <= '0;
    end else if (clk_en) begin
      if (state_reg == cmo_pkg::CMO_WAIT &&
          op_reg == cmo_pkg::OP_IDX_INV && wb_go) begin
        mem_wb_req <= 1'b1;
        mem_wb_addr <= tag_addr;
      end else if (state_reg == cmo_pkg::CMO_WB && mem_wb_done) begin
        mem_wb_req <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arr_wr_req <= 1'b0;
      arr_wvalid <= 1'b0;
      arr_wtag_low <= cmo_pkg::TAG_RST;
      arr_wtag_high <= cmo_pkg::TAG_RST;
    end else if (clk_en) begin
      arr_wr_req <= 1'b0;
      if (state_reg == cmo_pkg::CMO_WAIT) begin
        unique case (op_reg)
          cmo_pkg::OP_IDX_INV: begin
            if (!wb_go) begin
              // I-cache, clean or write-through: no writeback
              arr_wr_req <= 1'b1;
              arr_wvalid <= 1'b0;
              arr_wtag_low <= arr_rtag_low;
              arr_wtag_high <= arr_rtag_high;
            end
          end
          cmo_pkg::OP_STORE_TAG: begin
            arr_wr_req <= 1'b1;
            arr_wvalid <= tag_low_holding_reg[0];
            arr_wtag_low <= tag_low_holding_reg;
            arr_wtag_high <= tag_high_holding_reg;
          end
          cmo_pkg::OP_HIT_INV: begin
            if (hit_go) begin
              arr_wr_req <= 1'b1;
              arr_wvalid <= 1'b0;
              arr_wtag_low <= arr_rtag_low;
              arr_wtag_high <= arr_rtag_high;
            end
          end
          default: begin
            // Load tag, code 3 and codes 5 to 7 write nothing
            arr_wr_req <= 1'b0;
          end
        endcase
      end else if (state_reg == cmo_pkg::CMO_WB && mem_wb_done) begin
        arr_wr_req <= 1'b1;
        arr_wvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion pulses

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_done <= 1'b0;
      impl_op_pulse <= 1'b0;
    end else if (clk_en) begin
      op_done <= (state_reg == cmo_pkg::CMO_DONE);
      impl_op_pulse <= (state_reg == cmo_pkg::CMO_WAIT) &&
        (op_reg == cmo_pkg::OP_IMPL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding registers

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tag_low_holding_reg <= cmo_pkg::TAG_RST;
    end else if (clk_en) begin
      if (state_reg == cmo_pkg::CMO_WAIT &&
          op_reg == cmo_pkg::OP_LOAD_TAG) begin
        tag_low_holding_reg <= arr_rtag_low;
      end else if (tag_low_wr) begin
        tag_low_holding_reg <= tag_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tag_high_holding_reg <= cmo_pkg::TAG_RST;
    end else if (clk_en) begin
      if (state_reg == cmo_pkg::CMO_WAIT &&
          op_reg == cmo_pkg::OP_LOAD_TAG) begin
        tag_high_holding_reg <= arr_rtag_high;
      end else if (tag_high_wr) begin
        tag_high_holding_reg <= tag_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_low_holding_reg <= cmo_pkg::DATA_RST;
    end else if (clk_en) begin
      if (state_reg == cmo_pkg::CMO_WAIT &&
          op_reg == cmo_pkg::OP_LOAD_TAG) begin
        data_low_holding_reg <= arr_rdata_low;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_high_holding_reg <= cmo_pkg::DATA_RST;
    end else if (clk_en) begin
      if (state_reg == cmo_pkg::CMO_WAIT &&
          op_reg == cmo_pkg::OP_LOAD_TAG) begin
        data_high_holding_reg <= arr_rdata_high;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cache error report

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_cache_err <= 1'b0;
    end else if (clk_en) begin
      // Tag load/store never flag an error
      op_cache_err <= (state_reg == cmo_pkg::CMO_WAIT) && arr_rparity_err &&
        (op_reg != cmo_pkg::OP_LOAD_TAG) &&
        (op_reg != cmo_pkg::OP_STORE_TAG);
    end
  end

endmodule

// file: cmo_properties.sv
// Purpose: Port assertions for the cache maintenance engine
// Assumes: Requests held until op_done
// Notes: Bound from the testbench top
`timescale 1ns/1ps
module cmo_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire logic [31:0] op_instr,
  input wire logic [31:0] op_addr,
  input wire logic op_busy,
  input wire logic op_done,
  input wire logic op_cache_err,
  input wire logic [31:0] tag_low_holding_reg,
  input wire logic arr_rd_req,
  input wire logic arr_wr_req,
  input wire logic [1:0] arr_sel,
  input wire logic [8:0] arr_index,
  input wire logic [31:0] arr_addr,
  input wire logic [31:0] arr_wtag_low,
  input wire logic arr_wvalid,
  input wire logic mem_wb_req,
  input wire logic mem_wb_done,
  input wire logic impl_op_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !clk_en);
  ////////////////////////////////////////////////////////////////////////////
  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("done wider than one cycle");
  a_busy_req: assert property ((arr_rd_req || mem_wb_req) |->
    op_busy && !op_done) else $error("pipeline not held");
  a_rd_target: assert property (arr_rd_req |->
    arr_sel == op_instr[17:16] && arr_index == op_addr[13:5]
    && arr_addr == {op_addr[31:3], 3'h0})
    else $error("wrong cache, index or aligned address");
  a_finish_time: assert property (arr_rd_req |->
    ##[1:3] (op_done || mem_wb_req))
    else $error("operation did not finish");
  a_wb_hold: assert property (mem_wb_req && !mem_wb_done |=>
    mem_wb_req) else $error("writeback dropped early");
  a_wb_first: assert property (mem_wb_req |->
    !arr_wr_req && !op_done) else $error("invalidate before writeback");
  a_wb_then_inv: assert property (mem_wb_req && mem_wb_done |->
    ##[1:2] arr_wr_req) else $error("no invalidate after writeback");
  a_tag_no_err: assert property (op_busy && (
    op_instr[20:18] == cmo_pkg::OP_LOAD_TAG ||
    op_instr[20:18] == cmo_pkg::OP_STORE_TAG)
    |-> !op_cache_err) else $error("cache error on tag op");
  a_store_src: assert property (arr_wr_req && op_instr[20:18] ==
    cmo_pkg::OP_STORE_TAG |-> arr_wtag_low == tag_low_holding_reg
    && arr_wvalid == tag_low_holding_reg[0]) else $error("bad stored tag");
  a_inv_clear: assert property (arr_wr_req &&
    op_instr[19:18] == 2'h0 |-> !arr_wvalid)
    else $error("block left valid");
  a_impl_once: assert property (impl_op_pulse |->
    op_instr[20:18] == cmo_pkg::OP_IMPL ##1 !impl_op_pulse)
    else $error("bad implementation pulse");
endmodule

// file: cmo_array_model.sv
// Purpose: Cache array and writeback memory seen by the engine
// Assumes: Read data valid only in the cycle after arr_rd_req
// Notes: Lines show inverted values outside that cycle
`timescale 1ns/1ps
module cmo_array_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic arr_rd_req,
  input wire logic mem_wb_req,
  input wire logic [31:0] m_tag,
  input wire logic [2:0] m_flags,
  input wire logic [3:0] m_dly,
  output logic [31:0] arr_rtag_low,
  output logic [31:0] arr_rtag_high,
  output logic [31:0] arr_rdata_low,
  output logic [31:0] arr_rdata_high,
  output logic arr_rvalid_bit,
  output logic arr_rdirty_bit,
  output logic arr_rparity_err,
  output logic mem_wb_done
);
  logic rd_reg;
  logic [3:0] cnt_reg;
  logic [130:0] img;
  assign img = {m_tag, ~m_tag, m_tag ^ 32'hA5A5_A5A5, m_tag[15:0],
    m_tag[31:16], m_flags};
  assign {arr_rtag_low, arr_rtag_high, arr_rdata_low, arr_rdata_high,
    arr_rvalid_bit, arr_rdirty_bit, arr_rparity_err} = rd_reg ? img : ~img;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rd_reg <= 1'h0;
    else rd_reg <= arr_rd_req;
  end
  // Memory raises mem_wb_done m_dly+1 cycles after mem_wb_req rises
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 4'h0;
      mem_wb_done <= 1'h0;
    end else begin
      mem_wb_done <= mem_wb_req && !mem_wb_done && cnt_reg == m_dly;
      cnt_reg <= (mem_wb_req && !mem_wb_done) ? cnt_reg + 4'h1 : 4'h0;
    end
  end
endmodule

// file: cmo_engine_tb.sv
// Purpose: Self-checking bench for the cache maintenance engine
// Assumes: Inputs change on the falling edge
// Notes: clk_en held high except during t_freeze
`timescale 1ns/1ps
module cmo_engine_tb;
  logic clk = 0, sys_rst = 1, clk_en = 1, op_valid = 0;
  logic tag_low_wr = 0, tag_high_wr = 0;
  logic [31:0] op_instr = '0, op_addr = '0, tag_wdata = '0, m_tag = '0;
  logic [3:0] cache_wb_mode = '0, m_dly = '0;
  logic [2:0] m_flags = '0;
  logic op_busy, op_done, op_cache_err, arr_rd_req, arr_wr_req, arr_wvalid;
  logic mem_wb_req, mem_wb_done, impl_op_pulse, arr_rvalid_bit;
  logic arr_rdirty_bit, arr_rparity_err, wv;
  logic [31:0] tag_low_holding_reg, tag_high_holding_reg, arr_addr, wt, wba;
  logic [31:0] data_low_holding_reg, data_high_holding_reg, arr_wtag_low;
  logic [31:0] arr_wtag_high, mem_wb_addr, arr_rtag_low, arr_rtag_high;
  logic [31:0] arr_rdata_low, arr_rdata_high;
  logic [1:0] arr_sel;
  logic [8:0] arr_index;
  int n_mismatch = 0, checks_done = 0, n_wr, n_wb, n_err, n_imp;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  n_mismatch++; \
  $display("CHECK FAILED t=%0t %h %h", $time, a, b); \
  end end
  cmo_engine dut (.clk, .sys_rst, .clk_en, .op_valid, .op_instr, .op_addr,
    .op_busy, .op_done, .op_cache_err, .cache_wb_mode, .tag_low_wr,
    .tag_high_wr, .tag_wdata, .tag_low_holding_reg, .tag_high_holding_reg,
    .data_low_holding_reg, .data_high_holding_reg, .arr_rd_req, .arr_wr_req,
    .arr_sel, .arr_index, .arr_addr, .arr_wtag_low, .arr_wtag_high,
    .arr_wvalid, .arr_rtag_low, .arr_rtag_high, .arr_rdata_low,
    .arr_rdata_high, .arr_rvalid_bit, .arr_rdirty_bit, .arr_rparity_err,
    .mem_wb_req, .mem_wb_addr, .mem_wb_done, .impl_op_pulse);
  cmo_array_model model (.clk, .sys_rst, .arr_rd_req, .mem_wb_req, .m_tag,
    .m_flags, .m_dly, .arr_rtag_low, .arr_rtag_high, .arr_rdata_low,
    .arr_rdata_high, .arr_rvalid_bit, .arr_rdirty_bit, .arr_rparity_err,
    .mem_wb_done);
  always #5 clk = ~clk;
  always @(negedge clk) begin
    n_wr += arr_wr_req;
    n_wb += mem_wb_req;
    n_err += op_cache_err;
    n_imp += impl_op_pulse;
    if (arr_wr_req) {wt, wv} = {arr_wtag_low, arr_wvalid};
    if (mem_wb_req) wba = mem_wb_addr;
  end
  ////////////////////////////////////////////////////////////////////////////
  task run_op(input logic [2:0] op, input logic [1:0] s, input logic [31:0] a);
    int k;
    @(negedge clk);
    {n_wr, n_wb, n_err, n_imp} = '0;
    op_valid = 1;
    op_instr = {11'h0, op, s, 16'h0};
    op_addr = a;
    k = 0;
    do begin @(posedge clk); #1; k++; end while (op_done !== 1'b1 && k < 60);
    `CHK(k < 60, 1'b1)
    @(negedge clk);
    op_valid = 0;
    @(posedge clk);
    #1;
  endtask
  task t_inv;
    @(negedge clk);
    {cache_wb_mode, m_flags, m_tag} = {4'hC, 3'h6, 32'h1234_5678};
    run_op(cmo_pkg::OP_IDX_INV, cmo_pkg::SEL_PI, 32'h0000_1FE3);
    `CHK({n_wr, wv, n_wb}, {32'd1, 1'b0, 32'd0})
    run_op(cmo_pkg::OP_IDX_INV, cmo_pkg::SEL_PD, 32'h0000_0040);
    `CHK({n_wr, wv, n_wb}, {32'd1, 1'b0, 32'd0})
  endtask
  task t_wb;
    for (int s = 1; s < 4; s++) begin
      @(negedge clk);
      {cache_wb_mode, m_dly} = {4'hF, 4'(s * 3)};
      run_op(cmo_pkg::OP_IDX_INV, 2'(s), 32'h0000_2A45);
      `CHK({n_wb != 0, n_wr, wv}, {1'b1, 32'd1, 1'b0})
      `CHK(wba[31:5], {m_tag[31:14], 9'h152})
    end
    @(negedge clk);
    m_flags = 3'h4;
    run_op(cmo_pkg::OP_IDX_INV, cmo_pkg::SEL_SEC, 32'h0000_0020);
    `CHK({n_wr, wv, n_wb}, {32'd1, 1'b0, 32'd0})
  endtask
  task t_tags;
    @(negedge clk);
    {m_flags, m_tag} = {3'h1, 32'hDEAD_C0DE};
    run_op(cmo_pkg::OP_LOAD_TAG, cmo_pkg::SEL_TER, 32'h0000_0107);
    `CHK({tag_low_holding_reg, tag_high_holding_reg}, {m_tag, ~m_tag})
    `CHK(data_low_holding_reg, m_tag ^ 32'hA5A5_A5A5)
    `CHK(data_high_holding_reg, {m_tag[15:0], m_tag[31:16]})
    `CHK({n_err, n_wr}, 64'h0)
    for (int i = 0; i < 2; i++) begin
      @(negedge clk);
      {tag_low_wr, tag_high_wr} = 2'h3;
      tag_wdata = 32'h00C0_FFE0 + i;
      @(negedge clk);
      {tag_low_wr, tag_high_wr} = 2'h0;
      run_op(cmo_pkg::OP_STORE_TAG, cmo_pkg::SEL_PD, 32'(i * 32));
      `CHK({n_wr, n_err}, {32'd1, 32'd0})
      `CHK({wt, wv}, {tag_wdata, i[0]})
    end
  endtask
  task t_misc;
    for (int op = 3; op < 8; op++) begin
      run_op(3'(op), cmo_pkg::SEL_PD, 32'h0000_0000);
      `CHK(n_imp, int'(op == 3))
      if (op < 5) `CHK(n_err, 1)
    end
    @(negedge clk);
    {m_flags, m_tag} = {3'h4, 32'h0004_8000};
    run_op(cmo_pkg::OP_HIT_INV, cmo_pkg::SEL_PD, 32'h0004_8127);
    `CHK({n_wr, wv}, {32'd1, 1'b0})
    run_op(cmo_pkg::OP_HIT_INV, cmo_pkg::SEL_PI, 32'h0008_8127);
    `CHK(n_wr, 0)
  endtask
  task t_freeze;
    @(negedge clk);
    {clk_en, op_valid, op_addr} = {1'b0, 1'b1, 32'h0000_0000};
    op_instr = {11'h0, cmo_pkg::OP_HIT_INV, 18'h0};
    repeat (5) @(negedge clk);
    `CHK({op_done, arr_rd_req, op_busy}, 3'h1)
    clk_en = 1;
    repeat (4) @(negedge clk);
    `CHK(op_done, 1'b1)
    op_valid = 0;
    @(posedge clk);
    #1;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 0;
    t_inv;
    t_wb;
    t_tags;
    t_misc;
    t_freeze;
    wrap_up;
  end
  initial begin
    #20000;
    n_mismatch++;
    wrap_up;
  end
endmodule
bind cmo_engine cmo_properties u_chk (.clk, .sys_rst, .clk_en, .op_valid,
  .op_instr, .op_addr, .op_busy, .op_done, .op_cache_err, .arr_rd_req,
  .tag_low_holding_reg, .arr_wr_req, .arr_sel, .arr_index, .arr_addr,
  .arr_wtag_low, .arr_wvalid, .mem_wb_req, .mem_wb_done, .impl_op_pulse);
